// ---- uab_core.sv ----
`include "uab_params.svh"

// Functional notes
// R01: Written byte goes into transmit shift register, held until shifted out.
// R02: Writing the data buffer alone starts a transmission.
// R03: Reading the data buffer address returns the receive latch only.
// R04: One address, two registers: transmit shifter and receive latch, both reset zero.
// R05: Clock select 1 gives system clock; else prescale /12, /4, /48, external /8.
// R06: Software: 24.5 MHz, undivided clock, reload 0x96 for 115200 baud.
// R07: Software: 22.1184 MHz, undivided clock, reload 0xA0 for 115200 baud.
// R08: Software: external /8 source, reload 0xFA 230400, 0x70 9600 baud.
// R09: Bit period equals two timer overflows of (256 minus reload) prescaled ticks.
// R10: 9-bit frame: start, eight data LSB first, ninth bit, stop.
// R11: Load latch and set receive flag only if flag clear and address check passes.
// R12: Transmit flag set at stop-bit start, cleared by software only.
module uab_core #(
  parameter int FIFO_DEPTH = 32
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic [7:0]        sfr_addr,
  input  wire logic              sfr_wr,
  input  wire logic [7:0]        sfr_wdata,
  output logic      [7:0]        sfr_rdata,
  input  wire logic              baud_timer_clock_select,
  input  wire uab_pkg::uab_presc_e timer_prescale_select,
  input  wire logic [7:0]        baud_reload,
  input  wire logic              external_clock_source,
  input  wire logic              nine_bit_mode,
  input  wire logic              transmit_ninth_bit,
  input  wire logic              multiprocessor_check_enable,
  input  wire logic              receive_enable_bit,
  input  wire logic              tx_done_clr,
  input  wire logic              rx_done_clr,
  input  wire logic              rx_line,
  output logic                   tx_line,
  output logic                   tx_busy,
  output logic                   tx_done_flag,
  output logic                   rx_done_flag,
  output logic                   received_ninth_bit
);
  import uab_pkg::*;

  // ----------------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------------
  logic       ext_prev_ff;
  logic [5:0] pre_cnt_ff, nxt_pre_cnt;
  logic [5:0] pre_div;
  logic       pre_event;
  logic       tick;

  // Divisor and event source; prescale field ignored at full rate
  always_comb begin
    pre_div   = `UAB_DIV_SYS1;
    pre_event = 1'b1;
    if (!baud_timer_clock_select) begin
      unique case (timer_prescale_select)
        UAB_PRE_SYS12: pre_div = `UAB_DIV_SYS12; // R05
        UAB_PRE_SYS4:  pre_div = `UAB_DIV_SYS4;  // R05
        UAB_PRE_SYS48: pre_div = `UAB_DIV_SYS48; // R05
        UAB_PRE_EXT8: begin
          pre_div   = `UAB_DIV_EXT8;             // R05
          pre_event = external_clock_source & ~ext_prev_ff;
        end
      endcase
    end
    tick        = pre_event && (pre_cnt_ff >= pre_div - 6'h01);
    nxt_pre_cnt = pre_cnt_ff;
    if (tick) begin
      nxt_pre_cnt = '0;
    end else if (pre_event) begin
      nxt_pre_cnt = pre_cnt_ff + 6'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pre_cnt_ff  <= '0;
      ext_prev_ff <= 1'b0;
    end else begin
      pre_cnt_ff  <= nxt_pre_cnt;
      ext_prev_ff <= external_clock_source;
    end
  end

  // ----------------------------------------------------------------------
  // Baud timers: index 0 transmit, index 1 receive
  // ----------------------------------------------------------------------
  // Separate receive timer lets sampling phase lock to the start edge
  logic [1:0] tmr_restart;
  logic [1:0] tmr_ovf;
  logic [1:0] half_q;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_tmr
      logic [7:0] tmr_ff, nxt_tmr;
      logic       half_ff, nxt_half;
      // Two overflows of (256 - reload) ticks make one bit
      always_comb begin
        nxt_tmr     = tmr_ff;
        nxt_half    = half_ff;
        if (tmr_restart[gi]) begin
          nxt_tmr  = baud_reload;
          nxt_half = 1'b0;
        end else if (tmr_ovf[gi]) begin
          nxt_tmr  = baud_reload;                // R09
          nxt_half = ~half_ff;                   // R09
        end else if (tick) begin
          nxt_tmr = tmr_ff + 8'h01;
        end
      end
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          tmr_ff  <= '0;
          half_ff <= 1'b0;
        end else begin
          tmr_ff  <= nxt_tmr;
          half_ff <= nxt_half;
        end
      end
      // Kept out of the process so each bit has a single plain driver
      assign tmr_ovf[gi] = tick && (tmr_ff == `UAB_TIMER_TOP);
      assign half_q[gi]  = half_ff;
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------------
  uab_tx_state_e tx_st_ff, nxt_tx_st;
  logic [7:0]    tx_sh_ff, nxt_tx_sh;
  logic [2:0]    tx_cnt_ff, nxt_tx_cnt;
  logic          tx_nb_ff, nxt_tx_nb;
  logic          tx_line_ff, nxt_tx_line;
  logic          tx_done_ff, nxt_tx_done;
  logic          tx_busy_ff, nxt_tx_busy;
  logic          buf_wr;
  logic          tx_bit;

  assign buf_wr         = sfr_wr && (sfr_addr == `UAB_DATA_BUF_ADDR);
  assign tx_bit         = tmr_ovf[0] & half_q[0];
  assign tmr_restart[0] = buf_wr;

  // A write mid-frame aborts it and restarts with the new byte
  always_comb begin
    nxt_tx_st   = tx_st_ff;
    nxt_tx_sh   = tx_sh_ff;
    nxt_tx_cnt  = tx_cnt_ff;
    nxt_tx_nb   = tx_nb_ff;
    nxt_tx_line = tx_line_ff;
    nxt_tx_done = tx_done_ff & ~tx_done_clr;
    if (buf_wr) begin
      nxt_tx_sh   = sfr_wdata;                   // R01
      nxt_tx_nb   = transmit_ninth_bit;
      nxt_tx_line = 1'b0;                        // R02
      nxt_tx_st   = UAB_TX_START;                // R02
    end else if (tx_bit) begin
      unique case (tx_st_ff)
        UAB_TX_IDLE: ;
        UAB_TX_START, UAB_TX_DATA: begin
          if (tx_st_ff == UAB_TX_DATA && tx_cnt_ff == `UAB_LAST_DATA_BIT) begin
            if (nine_bit_mode) begin
              nxt_tx_line = tx_nb_ff;            // R10
              nxt_tx_st   = UAB_TX_NINTH;
            end else begin
              nxt_tx_line = 1'b1;
              nxt_tx_done = 1'b1;                // R12
              nxt_tx_st   = UAB_TX_STOP;
            end
          end else begin
            nxt_tx_line = tx_sh_ff[0];           // R10
            nxt_tx_sh   = {1'b0, tx_sh_ff[7:1]}; // R01
            nxt_tx_cnt  = (tx_st_ff == UAB_TX_START) ? 3'h0 : tx_cnt_ff + 3'h1;
            nxt_tx_st   = UAB_TX_DATA;
          end
        end
        UAB_TX_NINTH: begin
          nxt_tx_line = 1'b1;
          nxt_tx_done = 1'b1;                    // R12
          nxt_tx_st   = UAB_TX_STOP;
        end
        UAB_TX_STOP: nxt_tx_st = UAB_TX_IDLE;
      endcase
    end
    // Registered so the busy output comes straight from a flop
    nxt_tx_busy = (nxt_tx_st != UAB_TX_IDLE);
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tx_st_ff   <= UAB_TX_IDLE;
      tx_sh_ff   <= `UAB_DATA_BUF_RST;           // R04
      tx_cnt_ff  <= '0;
      tx_nb_ff   <= 1'b0;
      tx_line_ff <= 1'b1;
      tx_done_ff <= 1'b0;
      tx_busy_ff <= 1'b0;
    end else begin
      tx_st_ff   <= nxt_tx_st;
      tx_sh_ff   <= nxt_tx_sh;
      tx_cnt_ff  <= nxt_tx_cnt;
      tx_nb_ff   <= nxt_tx_nb;
      tx_line_ff <= nxt_tx_line;
      tx_done_ff <= nxt_tx_done;
      tx_busy_ff <= nxt_tx_busy;
    end
  end

  // ----------------------------------------------------------------------
  // Receiver front end
  // ----------------------------------------------------------------------
  uab_rx_state_e rx_st_ff, nxt_rx_st;
  logic [7:0]    rx_sh_ff, nxt_rx_sh;
  logic [2:0]    rx_cnt_ff, nxt_rx_cnt;
  logic          rx_nb_ff, nxt_rx_nb;
  logic          rx_prev_ff;
  logic          rx_smp;

  uab_stream_if #(.WIDTH(9)) rx_in ();
  uab_stream_if #(.WIDTH(9)) rx_out ();

  // Odd overflows fall mid-bit once the timer restarts on the edge
  assign rx_smp         = tmr_ovf[1] & ~half_q[1];
  assign tmr_restart[1] = (rx_st_ff == UAB_RX_IDLE);
  assign rx_in.valid    = (rx_st_ff == UAB_RX_HOLD);
  assign rx_in.data     = {rx_nb_ff, rx_sh_ff};

  always_comb begin
    nxt_rx_st  = rx_st_ff;
    nxt_rx_sh  = rx_sh_ff;
    nxt_rx_cnt = rx_cnt_ff;
    nxt_rx_nb  = rx_nb_ff;
    unique case (rx_st_ff)
      UAB_RX_IDLE: begin
        if (receive_enable_bit && rx_prev_ff && !rx_line) begin
          nxt_rx_st = UAB_RX_START;
        end
      end
      UAB_RX_START: begin
        if (rx_smp) begin
          nxt_rx_cnt = 3'h0;
          nxt_rx_st  = rx_line ? UAB_RX_IDLE : UAB_RX_DATA;
        end
      end
      UAB_RX_DATA: begin
        if (rx_smp) begin
          nxt_rx_sh  = {rx_line, rx_sh_ff[7:1]}; // R10
          nxt_rx_cnt = rx_cnt_ff + 3'h1;
          if (rx_cnt_ff == `UAB_LAST_DATA_BIT) begin
            nxt_rx_st = nine_bit_mode ? UAB_RX_NINTH : UAB_RX_STOP;
          end
        end
      end
      UAB_RX_NINTH: begin
        if (rx_smp) begin
          nxt_rx_nb = rx_line;                   // R10
          nxt_rx_st = UAB_RX_STOP;
        end
      end
      UAB_RX_STOP: begin
        if (rx_smp) begin
          // In 8-bit mode the stop bit takes the ninth bit's place
          nxt_rx_nb = nine_bit_mode ? rx_nb_ff : rx_line;
          if (!multiprocessor_check_enable || nxt_rx_nb) begin
            nxt_rx_st = UAB_RX_HOLD;             // R11
          end else begin
            nxt_rx_st = UAB_RX_IDLE;             // R11
          end
        end
      end
      UAB_RX_HOLD: begin
        // Stalls here while the buffer is full; line ignored meanwhile
        if (rx_in.ready) begin
          nxt_rx_st = UAB_RX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rx_st_ff   <= UAB_RX_IDLE;
      rx_sh_ff   <= '0;
      rx_cnt_ff  <= '0;
      rx_nb_ff   <= 1'b0;
      rx_prev_ff <= 1'b1;
    end else begin
      rx_st_ff   <= nxt_rx_st;
      rx_sh_ff   <= nxt_rx_sh;
      rx_cnt_ff  <= nxt_rx_cnt;
      rx_nb_ff   <= nxt_rx_nb;
      rx_prev_ff <= rx_line;
    end
  end

  uab_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .clock (clock),
    .rst_n (rst_n),
    .wr_s  (rx_in),
    .rd_s  (rx_out)
  );

  // ----------------------------------------------------------------------
  // Receive latch, flag and register read
  // ----------------------------------------------------------------------
  logic [7:0] rx_latch_ff, nxt_rx_latch;
  logic       rx_nb_out_ff, nxt_rx_nb_out;
  logic       rx_done_ff, nxt_rx_done;
  logic [7:0] rdata_ff, nxt_rdata;

  // Buffer drains only into an empty latch, so unread bytes survive
  assign rx_out.ready = ~rx_done_ff;             // R11

  always_comb begin
    nxt_rx_latch  = rx_latch_ff;
    nxt_rx_nb_out = rx_nb_out_ff;
    nxt_rx_done   = rx_done_ff & ~rx_done_clr;
    if (rx_out.valid && !rx_done_ff) begin
      nxt_rx_latch  = rx_out.data[7:0];          // R11
      nxt_rx_nb_out = rx_out.data[8];
      nxt_rx_done   = 1'b1;                      // R11
    end
    nxt_rdata = `UAB_READ_IDLE;
    if (sfr_addr == `UAB_DATA_BUF_ADDR) begin
      nxt_rdata = nxt_rx_latch;                  // R03
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rx_latch_ff  <= `UAB_DATA_BUF_RST;         // R04
      rx_nb_out_ff <= 1'b0;
      rx_done_ff   <= 1'b0;
      rdata_ff     <= `UAB_READ_IDLE;
    end else begin
      rx_latch_ff  <= nxt_rx_latch;
      rx_nb_out_ff <= nxt_rx_nb_out;
      rx_done_ff   <= nxt_rx_done;
      rdata_ff     <= nxt_rdata;
    end
  end

  assign sfr_rdata          = rdata_ff;
  assign tx_line            = tx_line_ff;
  assign tx_busy            = tx_busy_ff;
  assign tx_done_flag       = tx_done_ff;
  assign rx_done_flag       = rx_done_ff;
  assign received_ninth_bit = rx_nb_out_ff;
endmodule : uab_core

// ---- uab_params.svh ----
`ifndef UAB_PARAMS_SVH
`define UAB_PARAMS_SVH

// ----------------------------------------------------------------------
// Register map and reset values
// ----------------------------------------------------------------------
`define UAB_DATA_BUF_ADDR 8'h99
`define UAB_DATA_BUF_RST  8'h00
`define UAB_READ_IDLE     8'h00

// ----------------------------------------------------------------------
// Baud timer prescale divisors and counts
// ----------------------------------------------------------------------
`define UAB_DIV_SYS12     6'h0C
`define UAB_DIV_SYS4      6'h04
`define UAB_DIV_SYS48     6'h30
`define UAB_DIV_EXT8      6'h08
`define UAB_DIV_SYS1      6'h01
`define UAB_TIMER_TOP     8'hFF
`define UAB_LAST_DATA_BIT 3'h7

`endif

// ---- uab_pkg.sv ----
package uab_pkg;

  // ----------------------------------------------------------------------
  // Types shared by the serial port modules
  // ----------------------------------------------------------------------
  // Order gives codes 00 /12, 01 /4, 10 /48, 11 external /8
  typedef enum logic [1:0] {
    UAB_PRE_SYS12,
    UAB_PRE_SYS4,
    UAB_PRE_SYS48,
    UAB_PRE_EXT8
  } uab_presc_e;

  typedef enum logic [2:0] {
    UAB_TX_IDLE,
    UAB_TX_START,
    UAB_TX_DATA,
    UAB_TX_NINTH,
    UAB_TX_STOP
  } uab_tx_state_e;

  typedef enum logic [2:0] {
    UAB_RX_IDLE,
    UAB_RX_START,
    UAB_RX_DATA,
    UAB_RX_NINTH,
    UAB_RX_STOP,
    UAB_RX_HOLD
  } uab_rx_state_e;

endpackage : uab_pkg

// ---- uab_stream_if.sv ----
// Valid/ready carrier between receiver, buffer and receive latch
interface uab_stream_if #(
  parameter int WIDTH = 9
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : uab_stream_if

// ---- uab_fifo.sv ----
module uab_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input  wire logic   clock,
  input  wire logic   rst_n,
  uab_stream_if.snk   wr_s,
  uab_stream_if.src   rd_s
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_ff, nxt_wr_ptr;
  logic [PW-1:0]    rd_ptr_ff, nxt_rd_ptr;
  logic [CW-1:0]    count_ff,  nxt_count;
  logic             push;
  logic             pop;

  // ----------------------------------------------------------------------
  // Handshakes; full and empty come from the occupancy count
  // ----------------------------------------------------------------------
  assign wr_s.ready = (count_ff != FULL_CNT);
  assign rd_s.valid = (count_ff != '0);
  assign rd_s.data  = mem[rd_ptr_ff];
  assign push       = wr_s.valid & wr_s.ready;
  assign pop        = rd_s.valid & rd_s.ready;

  // Pointer wrap handles depths that are not a power of two
  always_comb begin
    nxt_wr_ptr = wr_ptr_ff;
    nxt_rd_ptr = rd_ptr_ff;
    nxt_count  = count_ff;
    if (push) begin
      nxt_wr_ptr = (wr_ptr_ff == LAST_PTR) ? '0 : wr_ptr_ff + 1'b1;
    end
    if (pop) begin
      nxt_rd_ptr = (rd_ptr_ff == LAST_PTR) ? '0 : rd_ptr_ff + 1'b1;
    end
    if (push && !pop) begin
      nxt_count = count_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_count = count_ff - 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff  <= nxt_count;
    end
  end

  // Storage needs no reset; empty flag guards stale words
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_ff] <= wr_s.data;
    end
  end
endmodule : uab_fifo

// ---- uab_core_props.sv ----
// ----------------------------------------------------------------------
// Port-level checks of the serial data buffer
// ----------------------------------------------------------------------
module uab_core_props (
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic [7:0] sfr_rdata,
  input wire logic       tx_line,
  input wire logic       tx_busy,
  input wire logic       tx_done_flag,
  input wire logic       tx_done_clr,
  input wire logic       rx_done_flag,
  input wire logic       rx_done_clr,
  input wire logic       received_ninth_bit,
  input wire logic       multiprocessor_check_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  import uab_pkg::*;
  // One domain, so clock and reset are given once
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  AST_TX_START: assert property (sfr_wr && sfr_addr == 8'h99 |=> !tx_line && tx_busy)
    else $error("data write did not start a frame");
  AST_TX_QUIET: assert property (!tx_busy && !(sfr_wr && sfr_addr == 8'h99) |=> !tx_busy)
    else $error("transmitter woke without a data write");
  AST_IDLE_HIGH: assert property (!tx_busy |-> tx_line)
    else $error("line low while transmitter idle");
  AST_RD_OTHER: assert property (sfr_addr != 8'h99 |=> sfr_rdata == 8'h00)
    else $error("read data not zero for other address");
  // Latch may not move while the receive flag blocks loading
  AST_RD_HOLD: assert property ((rx_done_flag && sfr_addr == 8'h99) [*3] |-> $stable(sfr_rdata))
    else $error("receive latch changed while flag set");
  AST_TX_FLAG_HOLD: assert property (tx_done_flag && !tx_done_clr |=> tx_done_flag)
    else $error("transmit flag dropped without clear");
  AST_RX_FLAG_HOLD: assert property (rx_done_flag && !rx_done_clr |=> rx_done_flag)
    else $error("receive flag dropped without clear");
  AST_TX_FLAG_STOP: assert property ($rose(tx_done_flag) |-> tx_line && tx_busy)
    else $error("transmit flag rose outside stop bit");
  AST_LOAD_WITH_FLAG: assert property ($changed(received_ninth_bit) |-> $rose(rx_done_flag))
    else $error("ninth bit loaded without receive flag");
  AST_MP_FILTER: assert property ($rose(rx_done_flag) && multiprocessor_check_enable |-> received_ninth_bit)
    else $error("address filter let a data frame through");
endmodule : uab_core_props

bind uab_core uab_core_props uab_core_props_inst (.clock, .rst_n, .sfr_addr, .sfr_wr,
  .sfr_rdata, .tx_line, .tx_busy, .tx_done_flag, .tx_done_clr, .rx_done_flag, .rx_done_clr,
  .received_ninth_bit, .multiprocessor_check_enable);

// ---- uab_remote_xcvr.sv ----
// ----------------------------------------------------------------------
// Far-end transceiver: sends frames into the receive line
// ----------------------------------------------------------------------
module uab_remote_xcvr #(
  parameter int BIT_CLKS = 4
) (
  input  wire logic clock,
  output logic      rx_line
);
  timeunit 1ns;
  timeprecision 1ps;
  // Line idles high between frames
  initial rx_line = 1'b1;

  // Start, data LSB first, ninth bit in long frames, stop
  task automatic send_frame(input logic [7:0] d, input logic ninth, input logic nine);
    logic [10:0] f;
    int          n;
    f = nine ? {1'b1, ninth, d, 1'b0} : {2'b11, d, 1'b0};
    n = nine ? 11 : 10;
    for (int i = 0; i < n; i++) begin
      @(negedge clock);
      rx_line <= f[i];
      repeat (BIT_CLKS - 1) @(negedge clock);
    end
  endtask : send_frame
endmodule : uab_remote_xcvr

// ---- uab_core_test.sv ----
module uab_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  import uab_pkg::*;
  // ----------------------------------------------------------------------
  // Stimulus, design and far end
  // ----------------------------------------------------------------------
  logic       clock = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] baud_reload = 8'hFE;
  logic [7:0] sfr_rdata, rv;
  logic [7:0] exp_latch = 8'h00;
  logic       sfr_wr = 1'b0, clk_sel = 1'b1, ext_clk = 1'b0, nine = 1'b0, ninth = 1'b0;
  logic       mce = 1'b0, ren = 1'b0, tx_clr = 1'b0, rx_clr = 1'b0;
  logic       rx_line, tx_line, tx_busy, tx_done_flag, rx_done_flag, received_ninth_bit;
  uab_presc_e presc = UAB_PRE_SYS12;
  int         fails = 0;
  int         cmp_count = 0;

  always #20 clock = ~clock;
  // External source at half the system rate
  always @(negedge clock) ext_clk <= ~ext_clk;

  uab_core uab_core_inst (.clock, .rst_n, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata,
    .baud_timer_clock_select(clk_sel), .timer_prescale_select(presc), .baud_reload,
    .external_clock_source(ext_clk), .nine_bit_mode(nine), .transmit_ninth_bit(ninth),
    .multiprocessor_check_enable(mce), .receive_enable_bit(ren), .tx_done_clr(tx_clr),
    .rx_done_clr(rx_clr), .rx_line, .tx_line, .tx_busy, .tx_done_flag, .rx_done_flag,
    .received_ninth_bit);
  uab_remote_xcvr #(.BIT_CLKS(4)) uab_remote_xcvr_inst (.clock, .rx_line);

  // ----------------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------------
  task automatic report_and_stop();
    if (fails == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    cmp_count++;
    if (s !== e) begin
      $display("BAD %s exp %h got %h", n, e, s);
      fails++;
    end
  endtask : chk

  // Bounded wait; a hang ends the run as a failure
  task automatic wait_for(ref logic s, input logic v, input int lim);
    int k = 0;
    while (s !== v) begin
      if (k++ > lim) begin
        $display("BAD wait exp %h got %h", v, s);
        fails++;
        report_and_stop();
      end
      @(negedge clock);
    end
  endtask : wait_for

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clock);
    sfr_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    sfr_addr = a;
    @(negedge clock);
    d = sfr_rdata;
  endtask : rd

  task automatic pulse(ref logic s);
    @(negedge clock);
    s = 1'b1;
    @(negedge clock);
    s = 1'b0;
  endtask : pulse

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset_vals();
    chk("tx_line", 8'h01, {7'h00, tx_line});
    chk("flags", 8'h00, {6'h00, tx_done_flag, rx_done_flag});
    rd(8'h99, rv);
    chk("latch", 8'h00, rv);
  endtask : t_reset_vals

  // Four clocks per bit; ninth bit sent low so it differs from stop
  task automatic t_tx_frame(input logic [7:0] d, input logic nb);
    logic [10:0] f;
    int          n;
    clk_sel = 1'b1;
    baud_reload = 8'hFE;
    nine = nb;
    ninth = 1'b0;
    f = {1'b1, !nb, d, 1'b0};
    n = nb ? 11 : 10;
    pulse(tx_clr);
    wr(8'h98, d);
    chk("busy_other", 8'h00, {7'h00, tx_busy});
    wr(8'h99, d);
    for (int i = 0; i < n; i++) begin
      chk("tx_bit", {7'h00, f[i]}, {7'h00, tx_line});
      chk("tx_done", {7'h00, i == n - 1}, {7'h00, tx_done_flag});
      repeat (4) @(negedge clock);
    end
    wait_for(tx_busy, 1'b0, 50);
    chk("tx_done_kept", 8'h01, {7'h00, tx_done_flag});
    rd(8'h99, rv);
    chk("rd_latch", exp_latch, rv);
    pulse(tx_clr);
  endtask : t_tx_frame

  // Width of data bit 0 for each timer source and tabled reload
  task automatic t_baud();
    logic       sel_t[6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    uab_presc_e p_t[6] = '{UAB_PRE_SYS12, UAB_PRE_SYS12, UAB_PRE_SYS12, UAB_PRE_SYS4,
                           UAB_PRE_SYS48, UAB_PRE_EXT8};
    logic [7:0] r_t[6] = '{8'h96, 8'hA0, 8'hFE, 8'hFE, 8'hFE, 8'hFA};
    logic [7:0] b_t[6] = '{8'hD4, 8'hC0, 8'h30, 8'h10, 8'hC0, 8'hC0};
    int         k;
    nine = 1'b0;
    for (int i = 0; i < 6; i++) begin
      clk_sel = sel_t[i];
      presc = p_t[i];
      baud_reload = r_t[i];
      wr(8'h99, 8'h01);
      wait_for(tx_line, 1'b1, 300);
      k = 0;
      while (tx_line === 1'b1 && k < 1000) begin
        k++;
        @(negedge clock);
      end
      chk("bit_clks", b_t[i], 8'(k));
      wait_for(tx_busy, 1'b0, 3000);
    end
  endtask : t_baud

  // Flag gating, held frame released by clear, address filter
  task automatic t_rx();
    clk_sel = 1'b1;
    baud_reload = 8'hFE;
    nine = 1'b1;
    ren = 1'b1;
    mce = 1'b0;
    uab_remote_xcvr_inst.send_frame(8'h3C, 1'b1, 1'b1);
    wait_for(rx_done_flag, 1'b1, 40);
    rd(8'h99, rv);
    chk("rx_byte", 8'h3C, rv);
    chk("rx_ninth", 8'h01, {7'h00, received_ninth_bit});
    uab_remote_xcvr_inst.send_frame(8'hA7, 1'b0, 1'b1);
    repeat (20) @(negedge clock);
    rd(8'h99, rv);
    chk("rx_blocked", 8'h3C, rv);
    pulse(rx_clr);
    wait_for(rx_done_flag, 1'b1, 40);
    rd(8'h99, rv);
    chk("rx_queued", 8'hA7, rv);
    chk("rx_ninth0", 8'h00, {7'h00, received_ninth_bit});
    pulse(rx_clr);
    mce = 1'b1;
    uab_remote_xcvr_inst.send_frame(8'h11, 1'b0, 1'b1);
    repeat (20) @(negedge clock);
    chk("rx_filtered", 8'h00, {7'h00, rx_done_flag});
    uab_remote_xcvr_inst.send_frame(8'h22, 1'b1, 1'b1);
    wait_for(rx_done_flag, 1'b1, 40);
    rd(8'h99, rv);
    chk("rx_address", 8'h22, rv);
    pulse(rx_clr);
    // Short frame: stop bit stands in for the ninth under the filter
    nine = 1'b0;
    uab_remote_xcvr_inst.send_frame(8'h5A, 1'b1, 1'b0);
    wait_for(rx_done_flag, 1'b1, 40);
    rd(8'h99, rv);
    chk("rx_short", 8'h5A, rv);
    pulse(rx_clr);
    mce = 1'b0;
    exp_latch = 8'h5A;
  endtask : t_rx

  initial begin
    repeat (5) @(negedge clock);
    rst_n = 1'b1;
    t_reset_vals();
    t_tx_frame(8'hA5, 1'b1);
    t_tx_frame(8'h3B, 1'b0);
    t_rx();
    t_tx_frame(8'hC4, 1'b1);
    t_baud();
    report_and_stop();
  end
endmodule : uab_core_test
